// [hw/iwd_watchdog.sv]
// i/o port watchdog: write loads and restarts, read disables, expiry fires
`timescale 1ns/1ps
`default_nettype none
`include "iwd_params.svh"
// Function
// - write to port 443h loads interval, starts
// - codes 01h to 3Eh give 1-62 seconds
// - rewrite before expiry reloads and restarts count
// - port read disables watchdog, no timeout
// - expiry resets cpu or raises interrupt
module iwd_watchdog #(
	parameter int unsigned TICK_CYC = `IWD_TICK_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire iwd_pkg::iwd_addr_t io_addr_in,
	input wire iwd_pkg::iwd_code_t io_wdata_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire iwd_pkg::iwd_action_t action_sel_in,
	output iwd_pkg::iwd_code_t io_rdata_out,
	output logic enabled_out,
	output logic cpu_reset_out,
	output logic irq_out
);
	import iwd_pkg::*;

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		logic en;
		iwd_code_t code;
		logic [5:0] remain;
		iwd_code_t rdata;
		logic rst_p;
		logic irq;
	} iwd_state_t;
	iwd_state_t state_q;
	iwd_state_t state_d;
	logic hit;
	logic wr_ok;
	logic tick;

	// port decode and code range check
	assign hit = (io_addr_in == `IWD_PORT_ADDR);
	assign wr_ok = hit && io_wr_in && (io_wdata_in >= `IWD_CODE_MIN)
		&& (io_wdata_in <= `IWD_CODE_MAX);

	//------------------------------------------------------------
	// time base
	//------------------------------------------------------------
	iwd_tick_div #(.TICK_CYC(TICK_CYC)) u_div (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.restart_in(wr_ok),
		.tick_out(tick)
	);

	//------------------------------------------------------------
	// countdown
	//------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.rst_p = 1'b0;
		if (hit && io_rd_in) begin
			state_d.rdata = state_q.code;
		end
		if (wr_ok) begin
			state_d.en = 1'b1;
			state_d.code = io_wdata_in;
			state_d.remain = io_wdata_in[5:0];
			state_d.irq = 1'b0;
		end else if (hit && io_rd_in) begin
			state_d.en = 1'b0;
		end else if (state_q.en && tick) begin
			if (state_q.remain == 6'h01) begin
				state_d.en = 1'b0;
				state_d.remain = 6'h00;
				if (action_sel_in == IWD_ACT_RESET) begin
					state_d.rst_p = 1'b1;
				end else begin
					state_d.irq = 1'b1;
				end
			end else begin
				state_d.remain = state_q.remain - 6'h01;
			end
		end
	end

	// register the whole state; reset leaves the watchdog off
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign io_rdata_out = state_q.rdata;
	assign enabled_out = state_q.en;
	assign cpu_reset_out = state_q.rst_p;
	assign irq_out = state_q.irq;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	sequence s_good_wr;
		wr_ok;
	endsequence
	sequence s_expire;
		state_q.en && tick && !wr_ok && !(hit && io_rd_in) && state_q.remain == 6'h01;
	endsequence

	AST_WR_ENABLES: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_good_wr |=> enabled_out && state_q.remain == $past(io_wdata_in[5:0]))
		else $error("good write did not enable");
	AST_BAD_CODE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(hit && io_wr_in && !wr_ok && !io_rd_in && !enabled_out) |=> !enabled_out)
		else $error("out of range code enabled");
	AST_RELOAD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_good_wr |=> !cpu_reset_out && !irq_out)
		else $error("reload did not clear expiry");
	AST_READ_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(hit && io_rd_in && !wr_ok) |=> !enabled_out ##1 !cpu_reset_out)
		else $error("read did not disable");
	AST_EXPIRE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_expire |=> (cpu_reset_out || irq_out) && !enabled_out)
		else $error("expiry gave no action");
	AST_NO_SPUR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(cpu_reset_out) |-> $past(state_q.en))
		else $error("reset pulse while disabled");
	AST_RESET_OFF: assert property (@(posedge ref_clk_in)
		!rst_n_in |=> !enabled_out && !irq_out && !cpu_reset_out)
		else $error("not disabled after reset");

	//------------------------------------------------------------
	// further checks on count, outputs and read data
	//------------------------------------------------------------
	// one tick while running and not yet at the last second
	sequence s_step;
		state_q.en && tick && !wr_ok && !(hit && io_rd_in) && state_q.remain > 6'h01;
	endsequence

	// a running count always holds a legal number of seconds
	AST_REMAIN_RANGE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		enabled_out |-> state_q.remain != 6'h00 && state_q.remain <= 6'h3E)
		else $error("remaining seconds out of range");

	// each tick takes exactly one second off the count
	AST_COUNT_STEP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		s_step |=> state_q.remain == $past(state_q.remain) - 6'h01)
		else $error("count did not step by one");

	// nothing but a port access or a tick moves the enable
	AST_IDLE_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!hit && !tick) |=> $stable(enabled_out))
		else $error("enable moved without cause");

	// a stopped watchdog never fires a reset
	AST_OFF_QUIET: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!state_q.en |=> !cpu_reset_out)
		else $error("reset pulse from stopped watchdog");

	// the reset pulse is one cycle wide
	AST_RST_PULSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		cpu_reset_out |=> !cpu_reset_out)
		else $error("reset pulse too long");

	// interrupt level stays until a good write clears it
	AST_IRQ_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(irq_out && !wr_ok) |=> irq_out)
		else $error("interrupt dropped early");

	// expiry with the interrupt action raises only the interrupt
	AST_EXPIRE_IRQ: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(s_expire and (action_sel_in == IWD_ACT_IRQ)) |=> irq_out && !cpu_reset_out)
		else $error("wrong expiry action");

	// a read returns the last accepted code
	AST_RDATA_CAP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(hit && io_rd_in) |=> io_rdata_out == $past(state_q.code))
		else $error("read data not the last code");

	// read data holds between reads
	AST_RDATA_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!(hit && io_rd_in) |=> $stable(io_rdata_out))
		else $error("read data changed without a read");
endmodule : iwd_watchdog
`default_nettype wire

// [hw/iwd_params.svh]
// constants for the i/o port watchdog: port address, code range and timing
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH
`define IWD_PORT_ADDR 16'h0443
`define IWD_CODE_MIN 8'h01
`define IWD_CODE_MAX 8'h3E
`define IWD_CLK_HZ 10000000
`define IWD_TICK_S 1
`define IWD_TICK_CYC (`IWD_CLK_HZ * `IWD_TICK_S)
`define IWD_CODE_RST 8'h00
`endif

// [hw/iwd_pkg.sv]
// types shared by the i/o port watchdog files
package iwd_pkg;
	typedef logic [7:0] iwd_code_t;
	typedef logic [15:0] iwd_addr_t;
	typedef enum logic {IWD_ACT_RESET, IWD_ACT_IRQ} iwd_action_t;
endpackage : iwd_pkg

// [hw/iwd_tick_div.sv]
// one-second tick divider for the watchdog countdown
`timescale 1ns/1ps
`default_nettype none
`include "iwd_params.svh"
module iwd_tick_div #(
	parameter int unsigned TICK_CYC = `IWD_TICK_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic restart_in,
	output logic tick_out
);
	typedef struct packed {
		logic [23:0] cnt;
		logic tick;
	} iwd_div_state_t;
	iwd_div_state_t state_q;
	iwd_div_state_t state_d;
	localparam logic [23:0] LAST = 24'(TICK_CYC - 1);

	// count cycles, pulse once per second, realign on restart
	always_comb begin
		state_d = state_q;
		state_d.tick = 1'b0;
		if (restart_in) begin
			state_d.cnt = 24'h000000;
		end else if (state_q.cnt == LAST) begin
			state_d.cnt = 24'h000000;
			state_d.tick = 1'b1;
		end else begin
			state_d.cnt = state_q.cnt + 24'h000001;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign tick_out = state_q.tick;
endmodule : iwd_tick_div
`default_nettype wire

// [test/test_io_port_watchdog_timer.sv]
// self-checking bench for the i/o port watchdog
`timescale 1ns/1ps
`default_nettype none
module test_io_port_watchdog_timer;
	import iwd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	iwd_action_t sel = IWD_ACT_RESET;
	iwd_addr_t addr = 16'h0443;
	iwd_code_t wdata = 8'h00;
	iwd_code_t rdata;
	logic en;
	logic crst;
	logic irq;
	int mismatches = 0;
	int n_checks = 0;
	iwd_code_t bad [3] = '{8'h00, 8'h3F, 8'hFF};
	// 10 MHz clock
	always #50 clk = ~clk;
	iwd_watchdog #(.TICK_CYC(10)) iwd_watchdog_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .io_addr_in(addr),
		.io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd), .action_sel_in(sel), .io_rdata_out(rdata),
		.enabled_out(en), .cpu_reset_out(crst), .irq_out(irq));
	// -------------------------
	// helpers
	// -------------------------
	function automatic logic [7:0] st();
		return {5'h00, crst, irq, en};
	endfunction : st
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one-cycle port access, write when w is high, read otherwise
	task acc(input iwd_addr_t a, input iwd_code_t d, input logic w);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = ~w;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask : acc
	task conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	// -------------------------
	// scenarios
	// -------------------------
	task t_bad();
		foreach (bad[i]) begin
			acc(16'h0443, bad[i], 1'b1);
			chk(st(), 8'h00);
		end
		acc(16'h0444, 8'h01, 1'b1);
		chk(st(), 8'h00);
	endtask : t_bad
	// expiry must land exactly n ticks after the write
	task t_expire(input iwd_code_t n, input iwd_action_t a);
		sel = a;
		acc(16'h0443, n, 1'b1);
		repeat (int'(n) * 10) @(negedge clk);
		chk(st(), 8'h01);
		@(negedge clk);
		chk(st(), (a == IWD_ACT_IRQ) ? 8'h02 : 8'h04);
		@(negedge clk);
		chk(st(), (a == IWD_ACT_IRQ) ? 8'h02 : 8'h00);
	endtask : t_expire
	task t_refresh();
		sel = IWD_ACT_RESET;
		acc(16'h0443, 8'h02, 1'b1);
		repeat (15) @(negedge clk);
		acc(16'h0443, 8'h02, 1'b1);
		chk(st(), 8'h01);
		repeat (20) @(negedge clk);
		chk(st(), 8'h01);
		@(negedge clk);
		chk(st(), 8'h04);
	endtask : t_refresh
	task t_read();
		acc(16'h0443, 8'h05, 1'b1);
		repeat (3) @(negedge clk);
		acc(16'h0443, 8'h00, 1'b0);
		chk(st(), 8'h00);
		chk(rdata, 8'h05);
		repeat (60) @(negedge clk);
		chk(st(), 8'h00);
	endtask : t_read
	// reset in mid-run while counting, then a read and a fresh write
	task t_reset();
		acc(16'h0443, 8'h03, 1'b1);
		repeat (2) @(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		chk(st(), 8'h00);
		acc(16'h0443, 8'h00, 1'b0);
		chk(rdata, 8'h00);
		chk(st(), 8'h00);
		acc(16'h0443, 8'h01, 1'b1);
		chk(st(), 8'h01);
	endtask : t_reset
	// main sequence after an 8-cycle reset
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		chk(st(), 8'h00);
		t_bad();
		t_expire(8'h01, IWD_ACT_RESET);
		t_expire(8'h3E, IWD_ACT_IRQ);
		t_refresh();
		t_read();
		t_reset();
		conclude();
	end
	// watchdog against a hang
	initial begin
		#300000;
		mismatches++;
		conclude();
	end
endmodule : test_io_port_watchdog_timer
`default_nettype wire
